// file: rss_sequencer.sv
// Summary of operation
// - reset pin asserts power-on, cold and warm resets together.
// - power-on reset held while pin asserted, released first afterwards.
// - defaults: switching mode, slow osc on, fast osc low frequency.
// - system clock select defaults to the fast oscillator.
// - after pin reset, strobe regulator to nominal switching mode for wait width.
// - cold and warm held until regulator ok, then released.
// - cold request bit asserts cold and warm only, regulator untouched.
// - cold reset clears registers except always-on and sticky ones.
// - hold until cold and warm triggers clear; cold request self-clears.
// - warm triggers: request bit, watchdog, redirected halt irq, shutdown.
// - irq triggers warm only if unmasked and redirect field zero.
// - processor shutdown gives full host warm reset.
// - warm asserts warm only, held until triggers clear; request bit clears.
// - warm resets host and non-sticky registers, no power cycling.
// - with latch-enables zero, oscillator power-down waits for halt.
// - exit-to-fast bit forces fast oscillator on wake.
// - on halt gate cpu and memory clocks per enable, power down oscillators.
// - with regulator-ok mask set, low regulator ok is ignored.
// - any wake event is latched and starts wake-up.
// - on wake, oscillator power-downs deassert asynchronously.
`timescale 1ns/1ns
`default_nettype none
module rss_sequencer #(
  parameter int IRQ_W = rss_pkg::RSS_IRQ_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              reset_pin_n,
  input  wire logic              watchdog_expired,
  input  wire logic              cpu_shutdown,
  input  wire logic              cpu_halted,
  input  wire logic [IRQ_W-1:0]  halt_irq,
  input  wire logic              wake_event,
  input  wire logic              regulator_ok,
  output rss_pkg::rss_resets_t   resets,
  output logic                   volt_select_strobe,
  output logic [4:0]             volt_select_field,
  output logic                   regulator_mode_sel,
  output rss_pkg::rss_osc_t      osc,
  output logic                   cpu_clk_en,
  output logic                   mem_clk_en,
  output logic                   wake_latched,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  if (IRQ_W < 1 || IRQ_W > 24) begin : g_irq_w_check
    $error("IRQ_W out of range");
  end

  localparam int SYNC_W = 4 + IRQ_W;

  // synchronised inputs
  logic [SYNC_W-1:0] sync_q;
  logic              pin_n_s, wdt_s, shut_s, halt_s;
  logic [IRQ_W-1:0]  irq_s;

  rss_sync #(.W(SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({reset_pin_n, watchdog_expired, cpu_shutdown, cpu_halted, halt_irq}),
    .q       (sync_q)
  );
  assign {pin_n_s, wdt_s, shut_s, halt_s, irq_s} = sync_q;

  // registers
  logic                     cold_req_r, warm_req_r;
  logic                     mode_r, rok_mask_r, strobe_bit_r;
  logic [4:0]               volt_select_field_r;
  logic                     clk_sel_r, exit_fast_r, fast_pd_r, slow_pd_r;
  logic                     fast_le_r, slow_le_r, freq_r;
  logic                     cpu_halt_en_r, mem_halt_en_r, redir_r;
  logic [IRQ_W-1:0]         irq_mask_r;
  logic [7:0]               wait_r;
  rss_pkg::rss_state_t      state_r, state_nxt;
  logic [7:0]               cnt_r;
  logic                     halt_seen_r;
  logic                     wake_r;

  // trigger decode
  logic pin_active, cold_trig, warm_trig, irq_trig, rok_eff;
  assign pin_active = !pin_n_s;
  assign irq_trig   = |(irq_s & ~irq_mask_r) && !redir_r;
  assign warm_trig  = warm_req_r || wdt_s || irq_trig || shut_s;
  assign cold_trig  = cold_req_r;
  assign rok_eff    = regulator_ok || rok_mask_r;

  // domain resets seen by registers here
  logic por_clr, cold_clr, warm_clr;
  assign por_clr  = !aresetn || pin_active;
  assign cold_clr = por_clr || state_r == rss_pkg::RSS_ST_COLD;
  assign warm_clr = cold_clr || state_r == rss_pkg::RSS_ST_WARM;

  // state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rss_pkg::RSS_ST_POR:    if (!pin_active) state_nxt = rss_pkg::RSS_ST_STROBE;
      rss_pkg::RSS_ST_STROBE: if (cnt_r == 8'h00) state_nxt = rss_pkg::RSS_ST_ROK;
      rss_pkg::RSS_ST_ROK:    if (rok_eff) state_nxt = rss_pkg::RSS_ST_RUN;
      rss_pkg::RSS_ST_RUN: begin
        if (cold_trig) state_nxt = rss_pkg::RSS_ST_COLD;
        else if (warm_trig) state_nxt = rss_pkg::RSS_ST_WARM;
      end
      rss_pkg::RSS_ST_COLD:   if (!cold_trig && !warm_trig) state_nxt = rss_pkg::RSS_ST_RUN;
      rss_pkg::RSS_ST_WARM:   if (!warm_trig) state_nxt = rss_pkg::RSS_ST_RUN;
      default:                state_nxt = rss_pkg::RSS_ST_POR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (por_clr) begin
      state_r <= rss_pkg::RSS_ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // strobe width counter
  always_ff @(posedge aclk) begin
    if (por_clr) begin
      cnt_r <= 8'h00;
    end else if (state_r == rss_pkg::RSS_ST_POR) begin
      cnt_r <= (wait_r == 8'h00) ? 8'h00 : wait_r - 8'h01;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // reset outputs
  always_ff @(posedge aclk) begin
    if (por_clr) begin
      resets <= '0;
    end else begin
      resets.por_n  <= 1'b1;
      resets.cold_n <= state_nxt == rss_pkg::RSS_ST_RUN || state_nxt == rss_pkg::RSS_ST_WARM;
      resets.warm_n <= state_nxt == rss_pkg::RSS_ST_RUN;
    end
  end

  // AXI4-Lite write path
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire, wr_hit;
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire = aw_hold_r && w_hold_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_rstc, wr_vreg, wr_clk, wr_halt, wr_wait;
  assign wr_rstc = wr_fire && w_strb_r[0] && aw_addr_r[7:2] == rss_pkg::RSS_OFF_RSTC[7:2];
  assign wr_vreg = wr_fire && aw_addr_r[7:2] == rss_pkg::RSS_OFF_VREG[7:2];
  assign wr_clk  = wr_fire && w_strb_r[0] && aw_addr_r[7:2] == rss_pkg::RSS_OFF_CLK[7:2];
  assign wr_halt = wr_fire && aw_addr_r[7:2] == rss_pkg::RSS_OFF_HALT[7:2];
  assign wr_wait = wr_fire && w_strb_r[0] && aw_addr_r[7:2] == rss_pkg::RSS_OFF_WAIT[7:2];
  assign wr_hit  = wr_rstc || wr_vreg || wr_clk || wr_halt || wr_wait ||
                   aw_addr_r[7:2] == rss_pkg::RSS_OFF_STAT[7:2] || !w_strb_r[0];

  // reset control requests: cleared by the reset they cause
  always_ff @(posedge aclk) begin
    if (cold_clr) begin
      cold_req_r <= 1'b0;
      warm_req_r <= 1'b0;
    end else if (state_r == rss_pkg::RSS_ST_WARM) begin
      warm_req_r <= 1'b0;
    end else if (wr_rstc) begin
      cold_req_r <= w_data_r[rss_pkg::RSS_COLD_RESET_REQUEST_BIT];
      warm_req_r <= w_data_r[rss_pkg::RSS_WARM_RESET_REQUEST_BIT];
    end
  end

  // regulator control: reset only by power-on reset
  always_ff @(posedge aclk) begin
    if (por_clr) begin
      mode_r       <= rss_pkg::RSS_MODE_SWITCHING;
      rok_mask_r   <= 1'b0;
      strobe_bit_r <= 1'b0;
      volt_select_field_r       <= rss_pkg::RSS_VOLT_SELECT_FIELD_NOMINAL;
      wait_r       <= rss_pkg::RSS_WAIT_RST;
    end else begin
      if (wr_vreg && w_strb_r[0]) begin
        mode_r       <= w_data_r[rss_pkg::RSS_VREG_MODE_BIT];
        rok_mask_r   <= w_data_r[rss_pkg::RSS_VREG_MASK_BIT];
        strobe_bit_r <= w_data_r[rss_pkg::RSS_VREG_STROBE_BIT];
      end
      if (wr_vreg && w_strb_r[1]) volt_select_field_r <= w_data_r[rss_pkg::RSS_VREG_VOLT_SELECT_FIELD_LSB +: 5];
      if (wr_wait) wait_r <= w_data_r[7:0];
    end
  end

  // clock and oscillator control: reset at cold reset
  always_ff @(posedge aclk) begin
    if (cold_clr) begin
      clk_sel_r   <= rss_pkg::RSS_SEL_FAST;
      exit_fast_r <= 1'b0;
      fast_pd_r   <= 1'b0;
      slow_pd_r   <= 1'b0;
      fast_le_r   <= 1'b1;
      slow_le_r   <= 1'b1;
      freq_r      <= rss_pkg::RSS_FREQ_LOW;
    end else if (wr_clk) begin
      clk_sel_r   <= w_data_r[rss_pkg::RSS_CLK_SEL_BIT];
      exit_fast_r <= w_data_r[rss_pkg::RSS_CLK_EXIT_FAST_BIT];
      fast_pd_r   <= w_data_r[rss_pkg::RSS_CLK_FAST_PD_BIT];
      slow_pd_r   <= w_data_r[rss_pkg::RSS_CLK_SLOW_PD_BIT];
      fast_le_r   <= w_data_r[rss_pkg::RSS_CLK_FAST_LE_BIT];
      slow_le_r   <= w_data_r[rss_pkg::RSS_CLK_SLOW_LE_BIT];
      freq_r      <= w_data_r[rss_pkg::RSS_CLK_FREQ_BIT];
    end else if (wake_r && exit_fast_r) begin
      clk_sel_r <= rss_pkg::RSS_SEL_FAST;
    end
  end

  // halt control and masks: non-sticky, reset at warm reset
  always_ff @(posedge aclk) begin
    if (warm_clr) begin
      cpu_halt_en_r <= 1'b0;
      mem_halt_en_r <= 1'b0;
      redir_r       <= 1'b1;
      irq_mask_r    <= '1;
    end else if (wr_halt) begin
      if (w_strb_r[0]) begin
        cpu_halt_en_r <= w_data_r[rss_pkg::RSS_HALT_CPU_EN_BIT];
        mem_halt_en_r <= w_data_r[rss_pkg::RSS_HALT_MEM_EN_BIT];
        redir_r       <= w_data_r[rss_pkg::RSS_HALT_REDIR_BIT];
      end
      irq_mask_r <= w_data_r[rss_pkg::RSS_HALT_MASK_LSB +: IRQ_W];
    end
  end

  // halt capture and wake latch; a wake takes priority over a new halt
  always_ff @(posedge aclk) begin
    if (warm_clr) begin
      halt_seen_r <= 1'b0;
      wake_r      <= 1'b0;
    end else begin
      if (wake_event) wake_r <= 1'b1;
      else if (!halt_s) wake_r <= 1'b0;
      if (wake_event || !halt_s) halt_seen_r <= 1'b0;
      else if (halt_s) halt_seen_r <= 1'b1;
    end
  end

  // power-down applies directly when latch-enabled, otherwise deferred to halt
  logic fast_pd_eff, slow_pd_eff;
  assign fast_pd_eff = fast_pd_r && (fast_le_r || halt_seen_r);
  assign slow_pd_eff = slow_pd_r && (slow_le_r || halt_seen_r);

  // wake clears the power-downs without waiting for the clock
  assign osc = '{fast_osc_powerdown: fast_pd_eff && !wake_event && !wake_r,
                 slow_osc_powerdown: slow_pd_eff && !wake_event && !wake_r,
                 sysclk_source_sel:  clk_sel_r,
                 fast_freq_high:     freq_r};

  assign cpu_clk_en = !(halt_seen_r && cpu_halt_en_r);
  assign mem_clk_en = !(halt_seen_r && mem_halt_en_r);
  assign wake_latched = wake_r;

  // regulator pins
  assign volt_select_strobe = state_r == rss_pkg::RSS_ST_STROBE || strobe_bit_r;
  assign volt_select_field  = volt_select_field_r;
  assign regulator_mode_sel = mode_r;

  // AXI4-Lite read path
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [5:0]  ra;
  assign s_axi_arready = !s_axi_rvalid;
  assign ra = s_axi_araddr[7:2];
  assign rd_hit = ra <= rss_pkg::RSS_OFF_STAT[7:2];
  assign rd_mux =
    ra == rss_pkg::RSS_OFF_RSTC[7:2] ? {30'h0, warm_req_r, cold_req_r} :
    ra == rss_pkg::RSS_OFF_VREG[7:2] ? {19'h0, volt_select_field_r, 2'h0, strobe_bit_r, 3'h0, rok_mask_r, mode_r} :
    ra == rss_pkg::RSS_OFF_CLK[7:2]  ? {25'h0, freq_r, slow_le_r, fast_le_r, slow_pd_r, fast_pd_r,
                                        exit_fast_r, clk_sel_r} :
    ra == rss_pkg::RSS_OFF_HALT[7:2] ? {{(24-IRQ_W){1'b0}}, irq_mask_r, 5'h0, redir_r, mem_halt_en_r,
                                        cpu_halt_en_r} :
    ra == rss_pkg::RSS_OFF_WAIT[7:2] ? {24'h0, wait_r} :
    ra == rss_pkg::RSS_OFF_STAT[7:2] ? {24'h0, regulator_ok, wake_r, halt_seen_r, 2'h0, state_r} :
                                       32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : rss_sequencer
`default_nettype wire

// file: rss_pkg.sv
package rss_pkg;

  // register byte offsets
  localparam logic [7:0] RSS_OFF_RSTC     = 8'h00;
  localparam logic [7:0] RSS_OFF_VREG     = 8'h04;
  localparam logic [7:0] RSS_OFF_CLK      = 8'h08;
  localparam logic [7:0] RSS_OFF_HALT     = 8'h0C;
  localparam logic [7:0] RSS_OFF_WAIT     = 8'h10;
  localparam logic [7:0] RSS_OFF_STAT     = 8'h14;

  // reset control fields
  localparam int RSS_COLD_RESET_REQUEST_BIT = 0;
  localparam int RSS_WARM_RESET_REQUEST_BIT = 1;

  // regulator control fields
  localparam int RSS_VREG_MODE_BIT   = 0;
  localparam int RSS_VREG_MASK_BIT   = 1;
  localparam int RSS_VREG_STROBE_BIT = 5;
  localparam int RSS_VREG_VOLT_SELECT_FIELD_LSB   = 8;
  localparam int RSS_VOLT_SELECT_FIELD_W          = 5;
  localparam logic [RSS_VOLT_SELECT_FIELD_W-1:0] RSS_VOLT_SELECT_FIELD_NOMINAL = 5'h10;
  localparam logic                  RSS_MODE_SWITCHING = 1'b0;

  // clock control fields
  localparam int RSS_CLK_SEL_BIT       = 0;
  localparam int RSS_CLK_EXIT_FAST_BIT = 1;
  localparam int RSS_CLK_FAST_PD_BIT   = 2;
  localparam int RSS_CLK_SLOW_PD_BIT   = 3;
  localparam int RSS_CLK_FAST_LE_BIT   = 4;
  localparam int RSS_CLK_SLOW_LE_BIT   = 5;
  localparam int RSS_CLK_FREQ_BIT      = 6;
  localparam logic RSS_SEL_FAST      = 1'b1;
  localparam logic RSS_FREQ_LOW      = 1'b0;

  // halt control fields
  localparam int RSS_HALT_CPU_EN_BIT = 0;
  localparam int RSS_HALT_MEM_EN_BIT = 1;
  localparam int RSS_HALT_REDIR_BIT  = 2;
  localparam int RSS_HALT_MASK_LSB   = 8;
  localparam int RSS_IRQ_W           = 8;

  // strobe wait field
  localparam int RSS_WAIT_W = 8;
  localparam logic [RSS_WAIT_W-1:0] RSS_WAIT_RST = 8'h04;

  typedef struct packed {
    logic por_n;
    logic cold_n;
    logic warm_n;
  } rss_resets_t;

  typedef struct packed {
    logic fast_osc_powerdown;
    logic slow_osc_powerdown;
    logic sysclk_source_sel;
    logic fast_freq_high;
  } rss_osc_t;

  typedef enum logic [2:0] {
    RSS_ST_POR    = 3'b000,
    RSS_ST_STROBE = 3'b001,
    RSS_ST_ROK    = 3'b011,
    RSS_ST_RUN    = 3'b010,
    RSS_ST_COLD   = 3'b110,
    RSS_ST_WARM   = 3'b111
  } rss_state_t;

endpackage : rss_pkg

// file: rss_sync.sv
`timescale 1ns/1ns
`default_nettype none
module rss_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // two-stage synchroniser; only the second stage is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : rss_sync
`default_nettype wire

// file: rss_sequencer_props.sv
`timescale 1ns/1ns
`default_nettype none
module rss_sequencer_props #(
  parameter int IRQ_W = rss_pkg::RSS_IRQ_W
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 reset_pin_n,
  input wire logic                 watchdog_expired,
  input wire logic                 cpu_shutdown,
  input wire logic                 cpu_halted,
  input wire logic                 wake_event,
  input wire logic                 regulator_ok,
  input wire rss_pkg::rss_resets_t resets,
  input wire logic                 volt_select_strobe,
  input wire logic [4:0]           volt_select_field,
  input wire logic                 regulator_mode_sel,
  input wire rss_pkg::rss_osc_t    osc,
  input wire logic                 cpu_clk_en,
  input wire logic                 mem_clk_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_all_low: assert property ($fell(reset_pin_n) |-> ##[1:4] (resets == 3'h0))
    else $error("pin reset did not assert all resets");
  a_por_hold: assert property (!reset_pin_n [*4] |-> !resets.por_n)
    else $error("power-on reset released while pin low");
  a_por_first: assert property ($rose(resets.por_n) |-> !resets.cold_n && !resets.warm_n)
    else $error("power-on reset not released first");
  a_strobe_follow: assert property ($rose(resets.por_n) |-> ##[0:2] volt_select_strobe)
    else $error("no strobe after pin reset");
  a_strobe_width: assert property ($rose(volt_select_strobe) && !resets.cold_n |->
    (volt_select_strobe && volt_select_field == rss_pkg::RSS_VOLT_SELECT_FIELD_NOMINAL &&
     regulator_mode_sel == rss_pkg::RSS_MODE_SWITCHING) [*4] ##1 !volt_select_strobe)
    else $error("strobe width or setting wrong");
  a_rok_release: assert property ($rose(resets.cold_n) |-> $past(regulator_ok))
    else $error("resets released before regulator ok");
  a_cold_no_por: assert property (reset_pin_n [*6] ##1 $fell(resets.cold_n) |->
    resets.por_n && !resets.warm_n && $stable(regulator_mode_sel))
    else $error("cold reset touched power-on reset or regulator");
  a_warm_trigger: assert property ((watchdog_expired || cpu_shutdown) [*6] |->
    !resets.warm_n && resets.por_n)
    else $error("warm trigger not holding warm reset");
  a_run_clocks: assert property (!cpu_halted [*4] |-> cpu_clk_en && mem_clk_en)
    else $error("clock gated while core running");
  a_wake_osc_on: assert property (wake_event |-> !osc.fast_osc_powerdown && !osc.slow_osc_powerdown)
    else $error("oscillator kept down on wake");
endmodule : rss_sequencer_props

bind rss_sequencer rss_sequencer_props #(.IRQ_W(IRQ_W)) rss_sequencer_props_inst (
  .aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n), .watchdog_expired(watchdog_expired),
  .cpu_shutdown(cpu_shutdown), .cpu_halted(cpu_halted), .wake_event(wake_event),
  .regulator_ok(regulator_ok), .resets(resets), .volt_select_strobe(volt_select_strobe),
  .volt_select_field(volt_select_field), .regulator_mode_sel(regulator_mode_sel), .osc(osc),
  .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en));
`default_nettype wire

// file: rss_regulator_model.sv
`timescale 1ns/1ns
`default_nettype none
module rss_regulator_model #(
  parameter int DLY = 20
) (
  input  wire logic aclk,
  input  wire logic volt_select_strobe,
  input  wire logic drop,
  output logic      regulator_ok
);
  logic ok_r;
  logic strobe_d;
  int   cnt;
  initial begin
    ok_r = 1'b1;
    strobe_d = 1'b0;
    cnt = 0;
  end
  // the drop input pulls the ok line low
  assign regulator_ok = ok_r && !drop;
  // regulation lost at the strobe's rising edge, regained DLY cycles later
  always @(posedge aclk) begin
    strobe_d <= volt_select_strobe;
    if (volt_select_strobe && !strobe_d) begin
      ok_r <= 1'b0;
      cnt <= DLY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      ok_r <= 1'b1;
    end
  end
endmodule : rss_regulator_model
`default_nettype wire

// file: test_soc_reset_and_sleep_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_soc_reset_and_sleep_sequencer;
  typedef struct packed {logic [7:0] a; logic [31:0] exp; logic [31:0] msk; logic [1:0] rsp;} rss_row_t;
  logic aclk, aresetn, reset_pin_n, watchdog_expired, cpu_shutdown, cpu_halted, wake_event, drop;
  logic regulator_ok, volt_select_strobe, regulator_mode_sel, cpu_clk_en, mem_clk_en, wake_latched;
  logic [7:0]  halt_irq, s_axi_awaddr, s_axi_araddr;
  logic [4:0]  volt_select_field;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  rss_pkg::rss_resets_t resets;
  rss_pkg::rss_osc_t    osc;
  int failures, total_checks, cyc;
  rss_row_t rows [7] = '{'{8'h00, 32'h0, 32'h3, 2'h0}, '{8'h04, 32'h1000, 32'h1F23, 2'h0},
    '{8'h08, 32'h31, 32'h7F, 2'h0}, '{8'h0C, 32'hFF04, 32'hFF04, 2'h0}, '{8'h10, 32'h4, 32'hFF, 2'h0},
    '{8'h14, 32'h82, 32'h87, 2'h0}, '{8'h18, 32'h0, 32'h0, 2'h2}};

  rss_sequencer rss_sequencer_inst (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
    .watchdog_expired(watchdog_expired), .cpu_shutdown(cpu_shutdown), .cpu_halted(cpu_halted),
    .halt_irq(halt_irq), .wake_event(wake_event), .regulator_ok(regulator_ok), .resets(resets),
    .volt_select_strobe(volt_select_strobe), .volt_select_field(volt_select_field),
    .regulator_mode_sel(regulator_mode_sel), .osc(osc), .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en),
    .wake_latched(wake_latched), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  rss_regulator_model rss_regulator_model_inst (.aclk(aclk), .volt_select_strobe(volt_select_strobe),
    .drop(drop), .regulator_ok(regulator_ok));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // each channel released at the edge where it is taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, (a > 8'h14) ? 2'h2 : 2'h0});
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {v, rr} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  task wait_rst(input int b, input logic v);
    int n;
    n = 0;
    while (resets[b] !== v && n < 500) begin
      @(negedge aclk);
      n++;
    end
    check("reset wait", {31'h0, resets[b]}, {31'h0, v});
  endtask : wait_rst

  initial begin
    {aresetn, watchdog_expired, cpu_shutdown, cpu_halted, wake_event, drop, halt_irq} = 0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, failures, total_checks, cyc} = 0;
    reset_pin_n = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wait_rst(1, 1'b1);
    for (int i = 0; i < 7; i++) begin
      rd(rows[i].a, d, r);
      check("reg read", d & rows[i].msk, rows[i].exp);
      check("read resp", {30'h0, r}, {30'h0, rows[i].rsp});
    end
    $display("test register defaults done");
    wr(rss_pkg::RSS_OFF_VREG, 32'h1001);
    @(posedge aclk) reset_pin_n <= 1'b0;
    repeat (6) @(negedge aclk);
    check("pin resets", 32'(resets), 32'h0);
    @(posedge aclk) reset_pin_n <= 1'b1;
    wait_rst(2, 1'b1);
    check("por first", 32'(resets), 32'h4);
    repeat (10) @(negedge aclk);
    check("rok wait", 32'(resets), 32'h4);
    wait_rst(1, 1'b1);
    check("after pin", {24'h0, regulator_mode_sel, 4'(osc), 3'(resets)}, 32'h17);
    $display("test pin reset done");
    wr(rss_pkg::RSS_OFF_VREG, 32'h1001);
    wr(rss_pkg::RSS_OFF_RSTC, 32'h1);
    wait_rst(1, 1'b0);
    check("cold", 32'(resets), 32'h4);
    wait_rst(1, 1'b1);
    rd(rss_pkg::RSS_OFF_RSTC, d, r);
    check("cold mode", {d[1:0], regulator_mode_sel}, 32'h1);
    wr(rss_pkg::RSS_OFF_VREG, 32'h1000);
    $display("test cold reset done");
    for (int k = 0; k < 4; k++) begin
      if (k == 3) wr(rss_pkg::RSS_OFF_HALT, 32'h0);
      if (k == 0) wr(rss_pkg::RSS_OFF_RSTC, 32'h2);
      @(posedge aclk) {halt_irq[0], cpu_shutdown, watchdog_expired} <= 3'(k == 3 ? 4 : k);
      wait_rst(0, 1'b0);
      check("warm only", 32'(resets), 32'h6);
      repeat (8) @(negedge aclk);
      if (k > 0) check("warm held", 32'(resets), (k == 3) ? 32'h7 : 32'h6);
      @(posedge aclk) {halt_irq[0], cpu_shutdown, watchdog_expired} <= 3'h0;
      wait_rst(0, 1'b1);
      rd(rss_pkg::RSS_OFF_HALT, d, r);
      check("halt regs", d & 32'hFF04, 32'hFF04);
    end
    @(posedge aclk) halt_irq <= 8'hFF;
    repeat (10) @(negedge aclk);
    check("masked irq", 32'(resets), 32'h7);
    wr(rss_pkg::RSS_OFF_HALT, 32'h4);
    repeat (10) @(negedge aclk);
    check("redirect off", 32'(resets), 32'h7);
    @(posedge aclk) halt_irq <= 8'h0;
    $display("test warm reset done");
    wr(rss_pkg::RSS_OFF_HALT, 32'hFF07);
    wr(rss_pkg::RSS_OFF_CLK, 32'h0E);
    check("pd deferred", {osc.fast_osc_powerdown, osc.slow_osc_powerdown}, 32'h0);
    @(posedge aclk) cpu_halted <= 1'b1;
    repeat (6) @(negedge aclk);
    check("halt gate", {cpu_clk_en, mem_clk_en, osc.fast_osc_powerdown, osc.slow_osc_powerdown}, 32'h3);
    @(posedge aclk) wake_event <= 1'b1;
    @(negedge aclk) check("wake pd", {osc.fast_osc_powerdown, osc.slow_osc_powerdown}, 32'h0);
    @(negedge aclk);
    @(negedge aclk) check("wake", {wake_latched, osc.sysclk_source_sel}, 32'h3);
    @(posedge aclk) {wake_event, cpu_halted} <= 2'h0;
    repeat (6) @(negedge aclk);
    check("clocks back", {cpu_clk_en, mem_clk_en}, 32'h3);
    $display("test halt and wake done");
    rd(rss_pkg::RSS_OFF_VREG, d, r);
    wr(rss_pkg::RSS_OFF_VREG, d | 32'h2);
    @(posedge aclk) drop <= 1'b1;
    repeat (10) @(negedge aclk);
    check("rok masked", 32'(resets), 32'h7);
    @(posedge aclk) drop <= 1'b0;
    // lower the voltage: field first, then strobe for 1 us, then 2 us settle
    wr(rss_pkg::RSS_OFF_VREG, (d & 32'hFFFF_E0FF) | 32'h0B02);
    wr(rss_pkg::RSS_OFF_VREG, (d & 32'hFFFF_E0FF) | 32'h0B22);
    check("soft strobe", {volt_select_strobe, volt_select_field}, 32'h2B);
    repeat (250) @(posedge aclk);
    wr(rss_pkg::RSS_OFF_VREG, (d & 32'hFFFF_E0FF) | 32'h0B02);
    check("strobe off", {volt_select_strobe, volt_select_field}, 32'h0B);
    repeat (500) @(posedge aclk);
    wr(8'h18, 32'h0);
    $display("test regulator mask done");
    results();
  end
endmodule : test_soc_reset_and_sleep_sequencer
`default_nettype wire
